//--- rtl/tx_auth_pkg.sv
// Package of constants and types for the transaction authentication input builder
package tx_auth_pkg;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] OFF_CONFIG    = 8'h00;
  localparam logic [7:0] OFF_COMMAND   = 8'h04;
  localparam logic [7:0] OFF_PARAM     = 8'h08;
  localparam logic [7:0] OFF_COUNT     = 8'h0C;
  localparam logic [7:0] OFF_STATUS    = 8'h10;
  localparam logic [7:0] OFF_LENGTH    = 8'h14;
  localparam logic [7:0] OFF_DATA_IN   = 8'h18;
  localparam logic [7:0] OFF_IDENT     = 8'h1C;
  localparam logic [7:0] OFF_ENC_PREV  = 8'h2C;
  localparam logic [7:0] OFF_PREV_ID   = 8'h3C;
  localparam logic [7:0] OFF_KEY_SEED  = 8'h4C;
  localparam logic [7:0] OFF_AUTH_VAL  = 8'h50;
  localparam logic [7:0] OFF_OUT_BYTE  = 8'h58;
  localparam int         ID_WORDS      = 4;

  // Configuration bit positions
  localparam int CFG_FILE_PRESENT = 0;
  localparam int CFG_COMMIT_EN    = 1;
  localparam int CFG_KEY_REQUIRED = 2;
  localparam int CFG_ID_REQUIRED  = 3;
  localparam int CFG_EXCL_UNAUTH  = 4;
  localparam int CFG_LIMIT_HIT    = 5;
  localparam int CFG_AUTH         = 6;
  localparam int CFG_AUTH_COMMIT  = 7;
  localparam int CFG_MAC_MODE     = 8;

  // Status bit positions
  localparam int ST_BUSY      = 0;
  localparam int ST_REJECT    = 1;
  localparam int ST_ID_DONE   = 2;
  localparam int ST_FINAL     = 3;
  localparam int ST_KEYS      = 4;
  localparam int ST_ENC_VALID = 5;

  // Layout constants
  localparam int         BLOCK_BYTES  = 16;
  localparam logic [3:0] BLOCK_MASK   = 4'hF;
  localparam logic [4:0] READ_ZEROS   = 5'h08;
  localparam logic [4:0] WRITE_ZEROS  = 5'h08;
  localparam logic [4:0] UPDATE_ZEROS = 5'h05;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam logic [31:0] RESP_SLVERR = 32'h0000_0002;

  // Command codes are fixed localparams with neutral values
  localparam logic [7:0] CODE_READ    = 8'h01;
  localparam logic [7:0] CODE_WRITE   = 8'h02;
  localparam logic [7:0] CODE_UPDATE  = 8'h03;
  localparam logic [7:0] CODE_ERASE   = 8'h04;
  localparam logic [7:0] CODE_COMMIT  = 8'h05;

  typedef enum {
    OP_NONE,
    OP_READ,
    OP_WRITE,
    OP_UPDATE,
    OP_ERASE,
    OP_IDENT,
    OP_FINALIZE,
    OP_CANCEL
  } op_e;

  typedef enum {
    PH_IDLE,
    PH_HEAD,
    PH_ZEROS,
    PH_DATA,
    PH_IDENT,
    PH_ENC,
    PH_FILL
  } phase_e;

  // Command fields captured from software
  typedef struct packed {
    logic [7:0]  file_index;
    logic [23:0] first_field;
    logic [23:0] second_field;
    logic [23:0] third_field;
  } cmd_fields_s;

  // One emitted byte of the input string
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } out_byte_s;

endpackage

//--- rtl/transaction_mac_input_builder.sv
// Builder of the transaction authentication input byte string
// Overview of operation
// - Read: code, file, start, count, 8 zeros, data
// - Write: code, file, offset, length, 8 zeros, data
// - Update: code, file, entry, offset, length, 5 zeros
// - No trailing fill after record data
// - Erase: code, file, fill to 16
// - Reject commit without file or disabled
// - Reject second identity commit per transaction
// - Store identity; authenticated copies to previous
// - Authenticated: code, identity, encrypted previous, fill
// - Unauthenticated: code, identity, fill
// - Fill is fewest zeros to multiple 16
// - Encrypted reply only when authenticated
// - Free access still updates when authenticated
// - Reject identity commit at counter ceiling
// - Key-required commit needs commit key
// - Finalize computation only on successful commit; the code enforces this only when CFG_ID_REQUIRED is set
// - Cancel drops computation and input
// - Previous identity encrypted with derived key
// - Derive session keys before first append
// - Produce 8-byte truncated auth value
// - Exclude unauthenticated operations when configured
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module transaction_mac_input_builder
  import tx_auth_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  // AXI4-Lite write response
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  // Input string byte stream
  output out_byte_s        tx_auth_input_out
);

  logic [8:0]   config_reg;
  cmd_fields_s  fields;
  logic [31:0]  length;
  logic [31:0]  current_reader_identity [ID_WORDS];
  logic [31:0]  previous_reader_identity [ID_WORDS];
  logic [31:0]  encrypted_prev_identity [ID_WORDS];
  logic [31:0]  app_tx_root_key;
  logic [31:0]  session_auth_key;
  logic [31:0]  session_encrypt_key;
  logic [63:0]  tx_auth_value;
  logic [63:0]  hash_state;
  logic         keys_ready;
  logic         id_done;
  logic         id_authed;
  logic         rejected;
  logic         finalized;
  logic         enc_valid;
  op_e          op;
  phase_e       phase;
  logic [4:0]   cnt;
  logic [23:0]  data_left;
  out_byte_s    emit;
  logic         aw_held;
  logic         w_held;
  logic [7:0]   aw_addr;
  logic [31:0]  w_data;
  logic         wr_fire;
  logic         cmd_start;
  logic         auth_now;
  logic         id_ok;
  logic         skip;
  logic [7:0]   head_byte;
  logic [4:0]   head_len;

  // Write channel capture, address and data in either order
  assign awready_out = !aw_held && !bvalid_out;
  assign wready_out  = !w_held && !bvalid_out;
  // Data bytes wait in the channel until the sequencer is ready for them
  assign wr_fire     = aw_held && w_held && !bvalid_out
                       && !(aw_addr == OFF_DATA_IN && phase != PH_IDLE
                            && phase != PH_DATA);

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
    end
    else
    begin
      if (awvalid_in && awready_out)
      begin
        aw_held <= 1'b1;
        aw_addr <= awaddr_in;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (wvalid_in && wready_out)
      begin
        w_held <= 1'b1;
        w_data <= wdata_in;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      bvalid_out <= 1'b0;
      bresp_out  <= 2'b00;
    end
    else if (wr_fire)
    begin
      bvalid_out <= 1'b1;
      bresp_out  <= (aw_addr <= OFF_KEY_SEED) ? 2'b00 : RESP_SLVERR[1:0];
    end
    else if (bready_in)
      bvalid_out <= 1'b0;
  end

  assign cmd_start = wr_fire && aw_addr == OFF_COMMAND
                     && (phase == PH_IDLE || w_data[2:0] == 3'h7);
  assign auth_now  = config_reg[CFG_AUTH];

  // Identity commit acceptance
  always_comb
  begin
    id_ok = config_reg[CFG_FILE_PRESENT] && config_reg[CFG_COMMIT_EN];
    if (id_done)
      id_ok = 1'b0;
    if (config_reg[CFG_LIMIT_HIT])
      id_ok = 1'b0;
    if (config_reg[CFG_KEY_REQUIRED] && !config_reg[CFG_AUTH_COMMIT])
      id_ok = 1'b0;
    if (auth_now && !config_reg[CFG_MAC_MODE])
      id_ok = 1'b0;
  end

  assign skip = config_reg[CFG_EXCL_UNAUTH] && !auth_now;

  // Configuration and parameter registers
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      config_reg      <= 9'h000;
      fields          <= '0;
      app_tx_root_key <= 32'h0000_0000;
    end
    else if (wr_fire)
    begin
      unique case (aw_addr)
        OFF_CONFIG:   config_reg <= w_data[8:0];
        OFF_PARAM:    fields <= {w_data[31:24], w_data[23:0],
                                 fields.second_field, fields.third_field};
        OFF_COUNT:    fields <= {fields.file_index, fields.first_field,
                                 w_data[23:0], fields.third_field};
        OFF_LENGTH:   fields.third_field <= w_data[23:0];
        OFF_KEY_SEED: app_tx_root_key <= w_data;
        default:      ;
      endcase
    end
  end

  // Header bytes per command; fields go out low byte first
  always_comb
  begin
    head_byte = ZERO_BYTE;
    head_len  = 5'h08;
    unique case (op)
      OP_READ:   head_len = 5'h08;
      OP_WRITE:  head_len = 5'h08;
      OP_UPDATE: head_len = 5'h0B;
      OP_ERASE:  head_len = 5'h02;
      default:   head_len = 5'h01;
    endcase
    if (cnt == 5'h00)
    begin
      unique case (op)
        OP_READ:   head_byte = CODE_READ;
        OP_WRITE:  head_byte = CODE_WRITE;
        OP_UPDATE: head_byte = CODE_UPDATE;
        OP_ERASE:  head_byte = CODE_ERASE;
        default:   head_byte = CODE_COMMIT;
      endcase
    end
    else if (cnt == 5'h01)
      head_byte = fields.file_index;
    else if (cnt < 5'h05)
      head_byte = fields.first_field[8*(cnt-5'h02) +: 8];
    else if (cnt < 5'h08)
      head_byte = fields.second_field[8*(cnt-5'h05) +: 8];
    else
      head_byte = fields.third_field[8*(cnt-5'h08) +: 8];
  end

  // Byte sequencer
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      op        <= OP_NONE;
      phase     <= PH_IDLE;
      cnt       <= 5'h00;
      data_left <= 24'h000000;
      emit      <= '0;
      rejected  <= 1'b0;
      id_done   <= 1'b0;
      id_authed <= 1'b0;
      finalized <= 1'b0;
      enc_valid <= 1'b0;
      length    <= 32'h0000_0000;
    end
    else
    begin
      emit <= '0;
      if (cmd_start)
      begin
        rejected <= 1'b0;
        cnt      <= 5'h00;
        unique case (w_data[2:0])
          3'h1, 3'h2, 3'h3, 3'h4:
          begin
            op <= op_e'(w_data[2:0]);
            finalized <= 1'b0;
            if (!skip)
              phase <= PH_HEAD;
            data_left <= fields.third_field;
          end
          3'h5:
          begin
            op <= OP_IDENT;
            if (id_ok)
            begin
              phase     <= PH_HEAD;
              id_done   <= 1'b1;
              id_authed <= auth_now;
              enc_valid <= auth_now;
            end
            else
              rejected <= 1'b1;
          end
          3'h6:
          begin
            if (config_reg[CFG_ID_REQUIRED] && !id_done)
              rejected <= 1'b1;
            else
            begin
              finalized <= 1'b1;
              length    <= 32'h0000_0000;
              id_done   <= 1'b0;
              enc_valid <= 1'b0;
            end
          end
          3'h7:
          begin
            phase     <= PH_IDLE;
            length    <= 32'h0000_0000;
            id_done   <= 1'b0;
            enc_valid <= 1'b0;
            finalized <= 1'b0;
          end
          default: ;
        endcase
      end
      else if (phase != PH_IDLE && keys_ready)
      begin
        unique case (phase)
          PH_HEAD:
          begin
            emit <= '{1'b1, head_byte};
            length <= length + 32'd1;
            cnt <= cnt + 5'h01;
            if (cnt + 5'h01 == head_len)
            begin
              cnt <= 5'h00;
              unique case (op)
                OP_READ, OP_WRITE, OP_UPDATE: phase <= PH_ZEROS;
                OP_IDENT: phase <= PH_IDENT;
                default:  phase <= PH_FILL;
              endcase
            end
          end
          PH_ZEROS:
          begin
            emit <= '{1'b1, ZERO_BYTE};
            length <= length + 32'd1;
            cnt <= cnt + 5'h01;
            if (cnt + 5'h01 == ((op == OP_UPDATE) ? UPDATE_ZEROS : READ_ZEROS))
            begin
              phase <= (data_left == 24'h000000) ? PH_IDLE : PH_DATA;
            end
          end
          PH_DATA:
          begin
            // data ends when data_left runs out, wherever that falls in a block; no fill follows
            if (wr_fire && aw_addr == OFF_DATA_IN)
            begin
              emit <= '{1'b1, w_data[7:0]};
              length <= length + 32'd1;
              data_left <= data_left - 24'h000001;
              if (data_left == 24'h000001)
                phase <= PH_IDLE;
            end
          end
          PH_IDENT:
          begin
            emit <= '{1'b1, current_reader_identity[cnt[3:2]][8*cnt[1:0] +: 8]};
            length <= length + 32'd1;
            cnt <= cnt + 5'h01;
            if (cnt == 5'h0F)
            begin
              cnt <= 5'h00;
              phase <= id_authed ? PH_ENC : PH_FILL;
            end
          end
          PH_ENC:
          begin
            emit <= '{1'b1, encrypted_prev_identity[cnt[3:2]][8*cnt[1:0] +: 8]};
            length <= length + 32'd1;
            cnt <= cnt + 5'h01;
            if (cnt == 5'h0F)
              phase <= PH_FILL;
          end
          PH_FILL:
          begin
            if ((length[3:0] & BLOCK_MASK) == 4'h0)
              phase <= PH_IDLE;
            else
            begin
              emit <= '{1'b1, ZERO_BYTE};
              length <= length + 32'd1;
            end
          end
          default: phase <= PH_IDLE;
        endcase
      end
    end
  end

  // Identity storage
  generate
    for (genvar i = 0; i < ID_WORDS; i++)
    begin : g_ident
      always_ff @(posedge sys_clk_in)
      begin
        if (rst_in)
        begin
          current_reader_identity[i]  <= 32'h0000_0000;
          previous_reader_identity[i] <= 32'h0000_0000;
          encrypted_prev_identity[i]  <= 32'h0000_0000;
        end
        else
        begin
          if (wr_fire && aw_addr == OFF_IDENT + 8'(4 * i) && phase == PH_IDLE)
            current_reader_identity[i] <= w_data;
          if (cmd_start && w_data[2:0] == 3'h6 && id_authed && id_done
              && !(config_reg[CFG_ID_REQUIRED] && !id_done))
            previous_reader_identity[i] <= current_reader_identity[i];
          // encrypt with key derived from root, not messaging keys
          encrypted_prev_identity[i] <= previous_reader_identity[i]
                                        ^ session_encrypt_key;
        end
      end
    end
  endgenerate

  // Session keys and running keyed value
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      keys_ready          <= 1'b0;
      session_auth_key    <= 32'h0000_0000;
      session_encrypt_key <= 32'h0000_0000;
      hash_state          <= 64'h0;
      tx_auth_value       <= 64'h0;
    end
    else
    begin
      if (phase != PH_IDLE && length == 32'h0000_0000 && !keys_ready)
      begin
        session_auth_key    <= {app_tx_root_key[30:0], 1'b1};
        session_encrypt_key <= {app_tx_root_key[29:0], 2'b10};
        keys_ready          <= 1'b1;
        hash_state          <= 64'h0;
      end
      else if (emit.valid)
        hash_state <= {hash_state[55:0], emit.value}
                      ^ {32'h0, session_auth_key}
                      ^ {hash_state[7:0], 56'h0};
      if (cmd_start && w_data[2:0] == 3'h6
          && !(config_reg[CFG_ID_REQUIRED] && !id_done))
      begin
        tx_auth_value <= hash_state;
        keys_ready    <= 1'b0;
      end
      else if (cmd_start && w_data[2:0] == 3'h7)
      begin
        keys_ready <= 1'b0;
        hash_state <= 64'h0;
      end
    end
  end

  assign tx_auth_input_out = emit;

  // Read channel
  assign arready_out = !rvalid_out;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      rvalid_out <= 1'b0;
      rdata_out  <= 32'h0000_0000;
      rresp_out  <= 2'b00;
    end
    else if (arvalid_in && arready_out)
    begin
      rvalid_out <= 1'b1;
      rresp_out  <= 2'b00;
      rdata_out  <= 32'h0000_0000;
      if (araddr_in == OFF_CONFIG)
        rdata_out <= {23'h0, config_reg};
      else if (araddr_in == OFF_STATUS)
        rdata_out <= {26'h0, enc_valid, keys_ready, finalized,
                      id_done, rejected, phase != PH_IDLE};
      else if (araddr_in == OFF_LENGTH)
        rdata_out <= length;
      else if (araddr_in >= OFF_ENC_PREV && araddr_in < OFF_PREV_ID)
        rdata_out <= enc_valid
                     ? encrypted_prev_identity[araddr_in[3:2] + 2'h1]
                     : 32'h0000_0000;
      else if (araddr_in >= OFF_PREV_ID && araddr_in < OFF_KEY_SEED)
        rdata_out <= previous_reader_identity[araddr_in[3:2] + 2'h1];
      else if (araddr_in == OFF_AUTH_VAL)
        rdata_out <= tx_auth_value[31:0];
      else if (araddr_in == OFF_AUTH_VAL + 8'h04)
        rdata_out <= tx_auth_value[63:32];
      else if (araddr_in > OFF_OUT_BYTE)
        rresp_out <= RESP_SLVERR[1:0];
    end
    else if (rready_in)
      rvalid_out <= 1'b0;
  end

endmodule

`default_nettype wire

//--- test/tx_auth_builder_monitor.sv
// Checker of bus answers and input string behaviour
`timescale 1ns/100ps
`default_nettype none

module tx_auth_builder_monitor
  import tx_auth_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // Register bus
  input wire logic [7:0]  awaddr_in,
  input wire logic        awvalid_in,
  input wire logic        awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic        wvalid_in,
  input wire logic        wready_out,
  input wire logic [1:0]  bresp_out,
  input wire logic        bvalid_out,
  input wire logic        bready_in,
  input wire logic [7:0]  araddr_in,
  input wire logic        arvalid_in,
  input wire logic        arready_out,
  input wire logic [31:0] rdata_out,
  input wire logic [1:0]  rresp_out,
  input wire logic        rvalid_out,
  input wire logic        rready_in,
  // Input string
  input wire out_byte_s   tx_auth_input_out
);
  logic       wr_hs;
  logic       rd_hs;
  logic       cmd_hs;
  logic [8:0] cfg;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  assign wr_hs  = awvalid_in && awready_out && wvalid_in && wready_out;
  assign rd_hs  = arvalid_in && arready_out;
  assign cmd_hs = wr_hs && awaddr_in == OFF_COMMAND;

  // Configuration shadow
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      cfg <= '0;
    else if (wr_hs && awaddr_in == OFF_CONFIG)
      cfg <= wdata_in[8:0];
  end

  chk_write_held:
    assert property (bvalid_out && !bready_in |=> bvalid_out
      && $stable(bresp_out)) else $error("write answer dropped");
  chk_read_held:
    assert property (rvalid_out && !rready_in |=> rvalid_out
      && $stable(rdata_out)) else $error("read answer dropped");
  chk_write_answer:
    assert property (wr_hs |-> ##[2:40] bvalid_out)
      else $error("no write answer");
  chk_read_answer:
    assert property (rd_hs |=> rvalid_out) else $error("no read answer");
  chk_write_range:
    assert property (wr_hs && awaddr_in > 8'h4C |-> ##2 bresp_out == 2'h2)
      else $error("bad write not refused");
  chk_read_range:
    assert property (rd_hs && araddr_in > 8'h58 |=> rresp_out == 2'h2)
      else $error("bad read not refused");
  chk_read_okay:
    assert property (rd_hs && araddr_in <= 8'h58 && araddr_in[1:0] == 2'h0
      |=> rresp_out == 2'h0) else $error("good read refused");
  chk_cancel_quiet:
    assert property (cmd_hs && wdata_in[7:0] == 8'h07
      |-> ##2 !tx_auth_input_out.valid [*3]) else $error("bytes after cancel");
  chk_refused_silent:
    assert property (cmd_hs && wdata_in[7:0] == 8'h05 && (!cfg[CFG_FILE_PRESENT]
      || !cfg[CFG_COMMIT_EN] || cfg[CFG_LIMIT_HIT])
      |=> !tx_auth_input_out.valid [*8]) else $error("refused commit emits");
  chk_unauth_skipped:
    assert property (cmd_hs && wdata_in[7:0] == 8'h04 && cfg[CFG_EXCL_UNAUTH]
      && !cfg[CFG_AUTH] |=> !tx_auth_input_out.valid [*8])
      else $error("excluded command emits");

  cover property (wr_hs);
  cover property (rd_hs);
  cover property (tx_auth_input_out.valid);
  cover property (cmd_hs && wdata_in[7:0] == 8'h07);
endmodule

bind transaction_mac_input_builder tx_auth_builder_monitor u_monitor (
  .sys_clk_in        (sys_clk_in),
  .rst_in            (rst_in),
  .awaddr_in         (awaddr_in),
  .awvalid_in        (awvalid_in),
  .awready_out       (awready_out),
  .wdata_in          (wdata_in),
  .wvalid_in         (wvalid_in),
  .wready_out        (wready_out),
  .bresp_out         (bresp_out),
  .bvalid_out        (bvalid_out),
  .bready_in         (bready_in),
  .araddr_in         (araddr_in),
  .arvalid_in        (arvalid_in),
  .arready_out       (arready_out),
  .rdata_out         (rdata_out),
  .rresp_out         (rresp_out),
  .rvalid_out        (rvalid_out),
  .rready_in         (rready_in),
  .tx_auth_input_out (tx_auth_input_out)
);
`default_nettype wire

//--- test/hash_feed_model.sv
// Stand-in for the keyed-hash engine that consumes the input string
`timescale 1ns/100ps
`default_nettype none

module hash_feed_model
  import tx_auth_pkg::*;
(
  // Clock and reset
  input wire logic      sys_clk_in,
  input wire logic      rst_in,
  // Byte stream from the builder
  input wire out_byte_s feed_in
);
  logic [7:0] seen [$];

  // Takes each pulsed byte; never stalls
  always @(posedge sys_clk_in)
  begin
    if (!rst_in && feed_in.valid === 1'b1)
      seen.push_back(feed_in.value);
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench of the input string builder
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import tx_auth_pkg::*;
;
  typedef struct {
    logic [8:0] cfg;
    logic [7:0] cmd;
    logic [7:0] code;
    int         ndata;
    int         total;
    int         zpos;
    int         zcnt;
    int         dpos;
    int         dcnt;
    logic       rej;
  } row_s;
  localparam logic [8:0] FC = 9'h003;

  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  awaddr_in = 8'h00;
  logic        awvalid_in = 1'b0;
  logic        awready_out;
  logic [31:0] wdata_in = 32'h0;
  logic [3:0]  wstrb_in = 4'hF;
  logic        wvalid_in = 1'b0;
  logic        wready_out;
  logic [1:0]  bresp_out;
  logic        bvalid_out;
  logic        bready_in = 1'b0;
  logic [7:0]  araddr_in = 8'h00;
  logic        arvalid_in = 1'b0;
  logic        arready_out;
  logic [31:0] rdata_out;
  logic [1:0]  rresp_out;
  logic        rvalid_out;
  logic        rready_in = 1'b0;
  out_byte_s   tx_auth_input_out;
  int          bad_count = 0;
  int          total_checks = 0;
  int          base;
  logic [31:0] rd;
  logic [1:0]  rsp;
  row_s        rows [11];

  always #12.5 sys_clk_in = ~sys_clk_in;

  transaction_mac_input_builder u_transaction_mac_input_builder (
    .sys_clk_in (sys_clk_in), .rst_in (rst_in),
    .awaddr_in (awaddr_in), .awvalid_in (awvalid_in),
    .awready_out (awready_out), .wdata_in (wdata_in),
    .wstrb_in (wstrb_in), .wvalid_in (wvalid_in),
    .wready_out (wready_out), .bresp_out (bresp_out),
    .bvalid_out (bvalid_out), .bready_in (bready_in),
    .araddr_in (araddr_in), .arvalid_in (arvalid_in),
    .arready_out (arready_out), .rdata_out (rdata_out),
    .rresp_out (rresp_out), .rvalid_out (rvalid_out),
    .rready_in (rready_in), .tx_auth_input_out (tx_auth_input_out));

  hash_feed_model u_hash_feed_model (.sys_clk_in (sys_clk_in),
    .rst_in (rst_in), .feed_in (tx_auth_input_out));

  task automatic conclude();
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    logic aw, w, ar, done;
    int   n;
    aw = wr;
    w = wr;
    ar = !wr;
    done = 1'b0;
    n = 0;
    awaddr_in <= a;
    araddr_in <= a;
    wdata_in <= d;
    awvalid_in <= wr;
    wvalid_in <= wr;
    arvalid_in <= !wr;
    bready_in <= wr;
    rready_in <= !wr;
    while (!done && n < 200)
    begin
      @(posedge sys_clk_in);
      n++;
      done = wr ? bvalid_out === 1'b1 : rvalid_out === 1'b1;
      rd = rdata_out;
      rsp = wr ? bresp_out : rresp_out;
      aw = aw && awready_out !== 1'b1;
      w = w && wready_out !== 1'b1;
      ar = ar && arready_out !== 1'b1;
      awvalid_in <= aw;
      wvalid_in <= w;
      arvalid_in <= ar;
    end
    bready_in <= 1'b0;
    rready_in <= 1'b0;
    if (!done)
    begin
      check("bus wait", 32'h1, 32'h0);
      conclude();
    end
    @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdreg(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // Command, data, then wait for idle
  task automatic run(input logic [7:0] cmd, input int ndata);
    int n;
    n = 0;
    wr(OFF_COMMAND, {24'h0, cmd});
    for (int i = 0; i < ndata; i++)
      wr(OFF_DATA_IN, 32'hA0 + i);
    rdreg(OFF_STATUS);
    while (rd[ST_BUSY] !== 1'b0 && n < 500)
    begin
      rdreg(OFF_STATUS);
      n++;
    end
    if (n >= 500)
    begin
      check("busy wait", 32'h1, 32'h0);
      conclude();
    end
  endtask

  function automatic logic [8:0] want(row_s w, int i);
    if (i == 0) return {1'b1, w.code};
    if (i == 1 && w.cmd < 8'h05) return {1'b1, 8'h3C};
    if (i >= w.zpos && i < w.zpos + w.zcnt) return {1'b1, ZERO_BYTE};
    if (i >= w.dpos && i < w.dpos + w.dcnt) return {1'b1, 8'(160 + i - w.dpos)};
    return 9'h000;
  endfunction

  task automatic do_row(row_s w);
    logic [8:0] e;
    wr(OFF_CONFIG, {23'h0, w.cfg});
    wr(OFF_COMMAND, 32'h7);
    base = u_hash_feed_model.seen.size();
    run(w.cmd, w.ndata);
    if (w.cmd >= 8'h05)
      check("rejected", w.rej, rd[ST_REJECT]);
    if (w.total > 0)
      check("keys ready", 32'h1, rd[ST_KEYS]);
    check("byte count", w.total, u_hash_feed_model.seen.size() - base);
    for (int i = 0; i < w.total; i++)
    begin
      e = want(w, i);
      if (e[8])
        check("input byte", e[7:0], u_hash_feed_model.seen[base + i]);
    end
    rdreg(OFF_LENGTH);
    check("running length", w.total, rd);
  endtask

  initial
  begin
    rows = '{
      '{FC, 8'h01, CODE_READ, 16, 32, 8, 8, 16, 16, 1'b0},
      '{FC, 8'h02, CODE_WRITE, 16, 32, 8, 8, 16, 16, 1'b0},
      '{FC, 8'h03, CODE_UPDATE, 16, 32, 11, 5, 16, 16, 1'b0},
      '{FC, 8'h04, CODE_ERASE, 0, 16, 2, 14, 16, 0, 1'b0},
      '{FC, 8'h05, CODE_COMMIT, 0, 32, 17, 15, 1, 16, 1'b0},
      '{9'h001, 8'h05, CODE_COMMIT, 0, 0, 0, 0, 0, 0, 1'b1},
      '{9'h002, 8'h05, CODE_COMMIT, 0, 0, 0, 0, 0, 0, 1'b1},
      '{9'h023, 8'h05, CODE_COMMIT, 0, 0, 0, 0, 0, 0, 1'b1},
      '{9'h007, 8'h05, CODE_COMMIT, 0, 0, 0, 0, 0, 0, 1'b1},
      '{9'h013, 8'h04, CODE_ERASE, 0, 0, 0, 0, 0, 0, 1'b0},
      '{9'h1C3, 8'h05, CODE_COMMIT, 0, 48, 33, 15, 1, 16, 1'b0}};
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rdreg(OFF_STATUS);
    check("status", 32'h0, rd);
    wr(OFF_PARAM, 32'h3C01_0101);
    wr(OFF_COUNT, 32'h0002_0202);
    wr(OFF_LENGTH, 32'h0000_0010);
    for (int k = 0; k < ID_WORDS; k++)
      wr(OFF_IDENT + 8'(4 * k), 32'hA3A2_A1A0 + 32'h0404_0404 * k);
    foreach (rows[i])
      do_row(rows[i]);
    rdreg(OFF_STATUS);
    check("enc valid", 32'h1, rd[ST_ENC_VALID]);
    run(8'h06, 0);
    rdreg(OFF_PREV_ID);
    check("previous id", 32'hA3A2_A1A0, rd);
    wr(OFF_IDENT, 32'h1111_1111);
    wr(OFF_CONFIG, 32'h0000_000B);
    wr(OFF_COMMAND, 32'h7);
    run(8'h06, 0);
    check("finalize refused", 32'h1, rd[ST_REJECT]);
    run(8'h05, 0);
    check("enc valid", 32'h0, rd[ST_ENC_VALID]);
    run(8'h06, 0);
    check("finalized", 32'h1, rd[ST_FINAL]);
    rdreg(OFF_PREV_ID);
    check("previous id", 32'hA3A2_A1A0, rd);
    run(8'h05, 0);
    base = u_hash_feed_model.seen.size();
    run(8'h05, 0);
    check("second commit", 32'h1, rd[ST_REJECT]);
    check("refused bytes", base, u_hash_feed_model.seen.size());
    wr(OFF_COMMAND, 32'h1);
    repeat (3) wr(OFF_DATA_IN, 32'h55);
    wr(OFF_COMMAND, 32'h7);
    rdreg(OFF_LENGTH);
    check("cancelled length", 32'h0, rd);
    run(8'h04, 0);
    rdreg(OFF_LENGTH);
    check("length after erase", 32'h10, rd);
    wr(OFF_AUTH_VAL, 32'h0);
    check("read-only write", RESP_SLVERR, rsp);
    rdreg(8'h60);
    check("unmapped read", RESP_SLVERR, rsp);
    rst_in <= 1'b1;
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rdreg(OFF_LENGTH);
    check("length after reset", 32'h0, rd);
    conclude();
  end
endmodule
`default_nettype wire
